// [include/fms_pkg.sv]
// package: fault and monitor status bank map, field layout and flag indices
// Operation
// - bridge two drain-source monitor flags, bits 6..3, latched until read-and-clear.
// - failsafe sink and electrochrome overcurrent flags latched until read-and-clear.
// - recovery alerts, bits 23..13, live level, untouched by read-and-clear.
// - bridge output short alerts, bits 7..0, latched until read-and-clear.
// - open-load flags, bits 23..7, latched until read-and-clear.
// - heater short monitor flag, bit 1, latched until read-and-clear.
// - watchdog phase at bits 23:22, codes 00, 01, 11 by third.
// - bit 17 live high while electrochrome voltage not yet reached.
// - bit 16 live high while electrochrome voltage above target.
// - per-cluster thermal warning flags, bits 13..8, latched until read-and-clear.
// - per-cluster thermal shutdown flags, bits 5..0, latched until read-and-clear.
// - even cluster temperature code at bits 21:12, never cleared.
// - odd cluster temperature code at bits 9:0, never cleared.
// - regulator supply code at bits 21:12, never cleared.
// - battery supply code at bits 21:12, never cleared.
// - wake pin voltage code at bits 9:0, never cleared.
// - CAN silence bit 5 is a live, pollable level.
// - CAN timeout flag bit 3 latched until read-and-clear.
// - wake pattern flag bit 2 latched until read-and-clear.
// - global thermal warning is the OR of cluster warning flags.
// - global thermal shutdown falls only when cluster shutdown flags clear.
// - writes to status registers are invalid, ignored and flagged.
package fms_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 24;
    localparam int CODE_W = 10;
    localparam int N_FLAG = 47;
    localparam int LIVE_W = 14;
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_BRIDGE = 7'h33;
    localparam logic [ADDR_W-1:0] OFF_ALERT = 7'h34;
    localparam logic [ADDR_W-1:0] OFF_OPEN = 7'h35;
    localparam logic [ADDR_W-1:0] OFF_THERM = 7'h36;
    localparam logic [ADDR_W-1:0] OFF_TEMP12 = 7'h37;
    localparam logic [ADDR_W-1:0] OFF_TEMP34 = 7'h38;
    localparam logic [ADDR_W-1:0] OFF_TEMP56 = 7'h39;
    localparam logic [ADDR_W-1:0] OFF_VREG = 7'h3A;
    localparam logic [ADDR_W-1:0] OFF_VSUP = 7'h3B;
    localparam logic [ADDR_W-1:0] OFF_CAN = 7'h3C;
    localparam logic [DATA_W-1:0] RST_DATA = 24'h00_0000;
    // field positions inside the 24-bit words
    localparam int BR_MON_LSB = 3;
    localparam int FS_OC_LSB = 0;
    localparam int ALERT_LSB = 13;
    localparam int SHORT_LSB = 0;
    localparam int OL_LSB = 7;
    localparam int HEAT_BIT = 1;
    localparam int EC_OC_BIT = 0;
    localparam int WD_LSB = 22;
    localparam int EC_LOW_BIT = 17;
    localparam int EC_HIGH_BIT = 16;
    localparam int TWARN_LSB = 8;
    localparam int TSHUT_LSB = 0;
    localparam int CODE_HI_LSB = 12;
    localparam int CODE_LO_LSB = 0;
    localparam int SILENT_BIT = 5;
    localparam int CAN_TO_BIT = 3;
    localparam int WAKE_PAT_BIT = 2;
    // positions in the latched flag vector
    localparam int F_BR = 0;
    localparam int F_FS = 4;
    localparam int F_SH = 6;
    localparam int F_OL = 14;
    localparam int F_HT = 31;
    localparam int F_EO = 32;
    localparam int F_WARN = 33;
    localparam int F_TS = 39;
    localparam int F_CT = 45;
    localparam int F_WP = 46;
endpackage

// [include/fms_flag_if.sv]
// interface: event, clear and latched flag vectors between bank and decoder
`timescale 1ns/1ps
interface fms_flag_if #(
    parameter int N = 47
);
    logic [N-1:0] evt;
    logic [N-1:0] clr;
    logic [N-1:0] flag;
    modport bank (input evt, input clr, output flag);
    modport user (output evt, output clr, input flag);
endinterface // fms_flag_if

// [src/fms_flag_bank.sv]
// module: synchronised sticky event flags with read-and-clear
`timescale 1ns/1ps
module fms_flag_bank #(
    parameter int N = 47
)(
    input wire logic clock, // 50 MHz device clock
    input wire logic rst, // synchronous, active high
    fms_flag_if.bank fl // events in, clears in, flags out
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] flag_r;

    // two flops before anything looks at an analog event
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= fl.evt;
            sync_r <= meta_r;
        end
    end

    generate
        for (genvar i = 0; i < N; i++) begin : g_flag
            always_ff @(posedge clock) begin
                if (rst) begin
                    flag_r[i] <= 1'b0;
                end else begin
                    flag_r[i] <= (flag_r[i] & ~fl.clr[i]) | sync_r[i];
                end
            end

            sequence evtThroughSync;
                fl.evt[i] ##3 1'b1;
            endsequence

            flag_after_evt_a: assert property (@(posedge clock) disable iff (rst)
                evtThroughSync |-> flag_r[i])
                else $error("event did not latch its flag");

            flag_hold_a: assert property (@(posedge clock) disable iff (rst)
                flag_r[i] && !fl.clr[i] |=> flag_r[i])
                else $error("latched flag dropped without a clear");
        end
    endgenerate

    assign fl.flag = flag_r;
endmodule // fms_flag_bank

// [src/fms_status_bank.sv]
// module: fault and monitor status register bank behind the serial command port
`timescale 1ns/1ps
module fms_status_bank
    import fms_pkg::*;
(
    input wire logic clock, // 50 MHz device clock
    input wire logic rst, // synchronous, active high
    input wire logic accValid, // one decoded frame, one cycle
    input wire logic accWrite, // frame asks to write
    input wire logic accClear, // frame is read-and-clear
    input wire logic [ADDR_W-1:0] accAddr, // register offset
    output logic [DATA_W-1:0] rdData, // read answer, registered
    output logic rdValid, // answer strobe, one cycle
    output logic invalidCmd, // rejected frame, one cycle
    input wire logic [3:0] bridgeTwoMonitorEvt, // hs2, hs1, ls2, ls1
    input wire logic [1:0] failsafeSinkOcEvt, // sink two, sink one
    input wire logic electrochromeOcEvt, // electrochrome overcurrent
    input wire logic [10:0] recoveryAlertIn, // live, msb is out1 high
    input wire logic [7:0] shortAlertEvt, // short threshold events
    input wire logic [16:0] openLoadEvt, // open-load events
    input wire logic heaterShortEvt, // heater short event
    input wire logic [1:0] watchdogPhase, // same-clock watchdog phase
    input wire logic ecvNotReachedIn, // live electrochrome low
    input wire logic ecvAboveTargetIn, // live electrochrome high
    input wire logic [5:0] clusterWarnEvt, // cluster 6..1 warning
    input wire logic [5:0] clusterShutEvt, // cluster 6..1 shutdown
    input wire logic [5:0][CODE_W-1:0] clusterTempCode, // same clock
    input wire logic [CODE_W-1:0] regulatorSupplyCode, // same clock
    input wire logic [CODE_W-1:0] batterySupplyCode, // same clock
    input wire logic [CODE_W-1:0] wakePinVoltageCode, // same clock
    input wire logic canSilentIn, // live bus silence
    input wire logic canTimeoutEvt, // bias to sleep transition
    input wire logic wakePatternEvt, // wake pattern received
    output logic globalThermalWarning, // or of warnings
    output logic globalThermalShutdown // or of shutdowns
);
    fms_flag_if #(.N(N_FLAG)) flagIf ();

    fms_flag_bank #(
        .N(N_FLAG)
    ) u_bank (
        .clock(clock),
        .rst(rst),
        .fl(flagIf.bank)
    );

    logic [LIVE_W-1:0] liveMeta_r;
    logic [LIVE_W-1:0] liveSync_r;
    logic [DATA_W-1:0] rdData_r;
    logic rdValid_r;
    logic invalidCmd_r;
    logic [DATA_W-1:0] regValue;
    logic [N_FLAG-1:0] clrMask;
    logic addrHit;
    logic readOk;
    logic [N_FLAG-1:0] flags;
    logic [10:0] alertLive;
    logic vnrLive;
    logic vhiLive;
    logic silentLive;

    assign flags = flagIf.flag;

    // event routing into the sticky bank
    always_comb begin
        flagIf.evt = '0;
        flagIf.evt[F_BR +: 4] = bridgeTwoMonitorEvt;
        flagIf.evt[F_FS +: 2] = failsafeSinkOcEvt;
        flagIf.evt[F_EO] = electrochromeOcEvt;
        flagIf.evt[F_SH +: 8] = shortAlertEvt;
        flagIf.evt[F_OL +: 17] = openLoadEvt;
        flagIf.evt[F_HT] = heaterShortEvt;
        flagIf.evt[F_WARN +: 6] = clusterWarnEvt;
        flagIf.evt[F_TS +: 6] = clusterShutEvt;
        flagIf.evt[F_CT] = canTimeoutEvt;
        flagIf.evt[F_WP] = wakePatternEvt;
    end

    // live levels come from analog comparators, so they are synchronised
    always_ff @(posedge clock) begin
        if (rst) begin
            liveMeta_r <= '0;
            liveSync_r <= '0;
        end else begin
            liveMeta_r <= {recoveryAlertIn, ecvNotReachedIn, ecvAboveTargetIn, canSilentIn};
            liveSync_r <= liveMeta_r;
        end
    end

    assign alertLive = liveSync_r[13:3];
    assign vnrLive = liveSync_r[2];
    assign vhiLive = liveSync_r[1];
    assign silentLive = liveSync_r[0];

    // word assembly and clear mask for the addressed register
    always_comb begin
        regValue = RST_DATA;
        clrMask = '0;
        addrHit = 1'b1;
        case (accAddr)
            OFF_BRIDGE: begin
                regValue[BR_MON_LSB +: 4] = flags[F_BR +: 4];
                regValue[FS_OC_LSB +: 2] = flags[F_FS +: 2];
                clrMask[F_BR +: 6] = '1;
            end
            OFF_ALERT: begin
                // recovery alerts are live and absent from the clear mask; short alerts are in it
                regValue[ALERT_LSB +: 11] = alertLive;
                regValue[SHORT_LSB +: 8] = flags[F_SH +: 8];
                clrMask[F_SH +: 8] = '1;
            end
            OFF_OPEN: begin
                regValue[OL_LSB +: 17] = flags[F_OL +: 17];
                regValue[HEAT_BIT] = flags[F_HT];
                regValue[EC_OC_BIT] = flags[F_EO];
                clrMask[F_OL +: 19] = '1;
            end
            OFF_THERM: begin
                regValue[WD_LSB +: 2] = watchdogPhase;
                regValue[EC_LOW_BIT] = vnrLive;
                regValue[EC_HIGH_BIT] = vhiLive;
                regValue[TWARN_LSB +: 6] = flags[F_WARN +: 6];
                regValue[TSHUT_LSB +: 6] = flags[F_TS +: 6];
                clrMask[F_WARN +: 12] = '1;
            end
            OFF_TEMP12: begin
                regValue[CODE_HI_LSB +: CODE_W] = clusterTempCode[1];
                regValue[CODE_LO_LSB +: CODE_W] = clusterTempCode[0];
            end
            OFF_TEMP34: begin
                regValue[CODE_HI_LSB +: CODE_W] = clusterTempCode[3];
                regValue[CODE_LO_LSB +: CODE_W] = clusterTempCode[2];
            end
            OFF_TEMP56: begin
                regValue[CODE_HI_LSB +: CODE_W] = clusterTempCode[5];
                regValue[CODE_LO_LSB +: CODE_W] = clusterTempCode[4];
            end
            OFF_VREG: begin
                regValue[CODE_HI_LSB +: CODE_W] = regulatorSupplyCode;
            end
            OFF_VSUP: begin
                regValue[CODE_HI_LSB +: CODE_W] = batterySupplyCode;
                regValue[CODE_LO_LSB +: CODE_W] = wakePinVoltageCode;
            end
            OFF_CAN: begin
                regValue[SILENT_BIT] = silentLive;
                regValue[CAN_TO_BIT] = flags[F_CT];
                regValue[WAKE_PAT_BIT] = flags[F_WP];
                clrMask[F_CT +: 2] = '1;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // writes and unmapped offsets never reach the bank
    assign readOk = accValid & ~accWrite & addrHit;

    // clear only latched flags of a valid read-and-clear
    assign flagIf.clr = (readOk & accClear) ? clrMask : '0;

    // answer carries the word as it stood before the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            rdData_r <= RST_DATA;
        end else if (readOk) begin
            rdData_r <= regValue;
        end
    end

    // answer strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= readOk;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            invalidCmd_r <= 1'b0;
        end else begin
            invalidCmd_r <= accValid & (accWrite | ~addrHit);
        end
    end

    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign invalidCmd = invalidCmd_r;

    assign globalThermalWarning = |flags[F_WARN +: 6];
    // global shutdown has no clear of its own
    assign globalThermalShutdown = |flags[F_TS +: 6];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence readReq;
        accValid && !accWrite && addrHit;
    endsequence

    sequence rcOf(logic [ADDR_W-1:0] off);
        accValid && !accWrite && accClear && accAddr == off;
    endsequence

    read_answer_a: assert property (readReq |=> rdValid && !invalidCmd)
        else $error("valid read got no answer");

    write_reject_a: assert property (accValid && accWrite |=> invalidCmd && !rdValid)
        else $error("status write was not rejected");

    write_no_clear_a: assert property (accValid && accWrite |-> flagIf.clr == '0)
        else $error("rejected write cleared a flag");

    alert_live_a: assert property (rcOf(OFF_ALERT) |=> rdData[23:13] == $past(alertLive))
        else $error("recovery alerts wrong in answer");

    alert_noclr_a: assert property (rcOf(OFF_ALERT) |-> flagIf.clr[F_OL +: 19] == '0)
        else $error("alert read cleared a foreign flag");

    wd_phase_a: assert property (readReq ##0 accAddr == OFF_THERM |=>
        rdData[23:22] == $past(watchdogPhase))
        else $error("watchdog phase misplaced");

    temp_code_a: assert property (readReq ##0 accAddr == OFF_TEMP12 |=>
        rdData[21:12] == $past(clusterTempCode[1]) && rdData[9:0] == $past(clusterTempCode[0]))
        else $error("temperature codes misplaced");

    warn_global_a: assert property (|clusterWarnEvt |-> ##3 globalThermalWarning)
        else $error("cluster warning missed global warning");

    shut_global_a: assert property (|clusterShutEvt |-> ##3 globalThermalShutdown)
        else $error("cluster shutdown missed global flag");

    shut_hold_a: assert property (globalThermalShutdown && !(|flagIf.clr[F_TS +: 6])
        |=> globalThermalShutdown)
        else $error("global shutdown fell without a cluster clear");

    can_old_a: assert property (rcOf(OFF_CAN) ##0 flags[F_CT] |=> rdData[3])
        else $error("read-and-clear lost old timeout value");

    reserved_zero_a: assert property (readReq ##0 accAddr == OFF_ALERT |=> rdData[12:8] == 5'h0)
        else $error("reserved alert bits not zero");

    // any read of one offset, with or without clear
    sequence readOf(logic [ADDR_W-1:0] off);
        accValid && !accWrite && accAddr == off;
    endsequence

    bridge_mon_a: assert property (readOf(OFF_BRIDGE) |=>
        rdData[6:3] == $past(flags[F_BR +: 4]))
        else $error("bridge monitor flags misplaced");

    sink_oc_a: assert property (readOf(OFF_BRIDGE) |=>
        rdData[1:0] == $past(flags[F_FS +: 2]) && !rdData[2])
        else $error("sink overcurrent flags misplaced");

    chrome_oc_a: assert property (readOf(OFF_OPEN) |=>
        rdData[0] == $past(flags[F_EO]))
        else $error("electrochrome overcurrent misplaced");

    short_alert_a: assert property (readOf(OFF_ALERT) |=>
        rdData[7:0] == $past(flags[F_SH +: 8]))
        else $error("short alerts misplaced");

    open_load_a: assert property (readOf(OFF_OPEN) |=>
        rdData[23:7] == $past(flags[F_OL +: 17]) && rdData[6:2] == 5'h0)
        else $error("open-load flags misplaced");

    heater_mon_a: assert property (readOf(OFF_OPEN) |=>
        rdData[1] == $past(flags[F_HT]))
        else $error("heater monitor misplaced");

    chrome_low_a: assert property (readOf(OFF_THERM) |=>
        rdData[17] == $past(vnrLive))
        else $error("voltage not reached misplaced");

    chrome_high_a: assert property (readOf(OFF_THERM) |=>
        rdData[16] == $past(vhiLive))
        else $error("voltage above target misplaced");

    cluster_warn_a: assert property (readOf(OFF_THERM) |=>
        rdData[13:8] == $past(flags[F_WARN +: 6]))
        else $error("cluster warnings misplaced");

    cluster_shut_a: assert property (readOf(OFF_THERM) |=>
        rdData[5:0] == $past(flags[F_TS +: 6]) && rdData[7:6] == 2'h0)
        else $error("cluster shutdowns misplaced");

    odd_code_a: assert property (readOf(OFF_TEMP56) |=>
        rdData[9:0] == $past(clusterTempCode[4])
        && rdData[21:12] == $past(clusterTempCode[5]))
        else $error("cluster five and six codes misplaced");

    vreg_code_a: assert property (readOf(OFF_VREG) |=>
        rdData[21:12] == $past(regulatorSupplyCode) && rdData[11:0] == 12'h000)
        else $error("regulator code misplaced");

    vsup_code_a: assert property (readOf(OFF_VSUP) |=>
        rdData[21:12] == $past(batterySupplyCode))
        else $error("battery code misplaced");

    wake_code_a: assert property (readOf(OFF_VSUP) |=>
        rdData[9:0] == $past(wakePinVoltageCode))
        else $error("wake pin code misplaced");

    can_silent_a: assert property (readOf(OFF_CAN) |=>
        rdData[5] == $past(silentLive))
        else $error("bus silence bit misplaced");

    wake_flag_a: assert property (readOf(OFF_CAN) |=>
        rdData[2] == $past(flags[F_WP]))
        else $error("wake pattern flag misplaced");

    unmapped_reject_a: assert property (accValid && !addrHit |=>
        invalidCmd && !rdValid)
        else $error("unmapped offset was not rejected");

    warn_read_a: assert property (readOf(OFF_THERM) ##0 globalThermalWarning |=>
        |rdData[13:8])
        else $error("global warning without a cluster flag");
endmodule // fms_status_bank

// [test/fms_host_model.sv]
// host side model that issues decoded command frames to the status bank
`timescale 1ns/1ps
module fms_host_model
    import fms_pkg::*;
(
    input wire logic clock, // device clock
    output logic accValid, // frame strobe
    output logic accWrite, // write request
    output logic accClear, // read-and-clear request
    output logic [ADDR_W-1:0] accAddr // register offset
);
    // idle at time zero
    initial begin
        accValid = 1'b0;
        accWrite = 1'b0;
        accClear = 1'b0;
        accAddr = '0;
    end
    // one frame, held until the next edge takes it
    // writes only when asked
    task automatic frame(input logic w, input logic c, input logic [ADDR_W-1:0] a);
        @(posedge clock);
        #1;
        accValid = 1'b1;
        accWrite = w;
        accClear = c;
        accAddr = a;
    endtask
    // released lines toggle so a stale value is never mistaken for a frame field
    task automatic idle();
        @(posedge clock);
        #1;
        accValid = 1'b0;
        accWrite = ~accWrite;
        accClear = ~accClear;
        accAddr = ~accAddr;
    endtask
endmodule // fms_host_model

// [test/fault_and_monitor_status_bank_test.sv]
// self-checking bench for the fault and monitor status bank
`timescale 1ns/1ps
module fault_and_monitor_status_bank_test
    import fms_pkg::*;
;
    typedef struct packed {logic isErr; logic [DATA_W-1:0] word;} fms_note_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic accValid, accWrite, accClear, rdValid, invalidCmd;
    logic [ADDR_W-1:0] accAddr;
    logic [DATA_W-1:0] rdData;
    logic globalThermalWarning, globalThermalShutdown;
    logic [3:0] bridgeTwoMonitorEvt;
    logic [1:0] failsafeSinkOcEvt, watchdogPhase = 2'h0;
    logic electrochromeOcEvt, heaterShortEvt, canTimeoutEvt, wakePatternEvt;
    logic [10:0] recoveryAlertIn = 11'h000;
    logic [7:0] shortAlertEvt;
    logic [16:0] openLoadEvt;
    logic [5:0] clusterWarnEvt, clusterShutEvt;
    logic ecvNotReachedIn = 1'b0, ecvAboveTargetIn = 1'b0, canSilentIn = 1'b0;
    logic [5:0][CODE_W-1:0] clusterTempCode = '0;
    logic [CODE_W-1:0] regulatorSupplyCode = '0, batterySupplyCode = '0;
    logic [CODE_W-1:0] wakePinVoltageCode = '0;
    logic [N_FLAG-1:0] evt = '0; // all sticky events, flag vector order
    logic [N_FLAG-1:0] stk = '0; // expected sticky flags
    logic [31:0] seed = 32'h0000_001B;
    fms_note_t q[$];
    fms_note_t got;
    int errCount = 0;
    int compares = 0;

    always #10 clock = ~clock;

    // spread the event vector over the event ports
    assign {wakePatternEvt, canTimeoutEvt, clusterShutEvt, clusterWarnEvt, electrochromeOcEvt,
            heaterShortEvt, openLoadEvt, shortAlertEvt, failsafeSinkOcEvt,
            bridgeTwoMonitorEvt} = evt;

    fms_host_model host_u (.clock, .accValid, .accWrite, .accClear, .accAddr);

    fms_status_bank dut_u (
        .clock, .rst, .accValid, .accWrite, .accClear, .accAddr, .rdData, .rdValid,
        .invalidCmd, .bridgeTwoMonitorEvt, .failsafeSinkOcEvt, .electrochromeOcEvt,
        .recoveryAlertIn, .shortAlertEvt, .openLoadEvt, .heaterShortEvt, .watchdogPhase,
        .ecvNotReachedIn, .ecvAboveTargetIn, .clusterWarnEvt, .clusterShutEvt,
        .clusterTempCode, .regulatorSupplyCode, .batterySupplyCode, .wakePinVoltageCode,
        .canSilentIn, .canTimeoutEvt, .wakePatternEvt, .globalThermalWarning,
        .globalThermalShutdown
    );

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected word of one register from the sticky model and live inputs
    function automatic logic [DATA_W-1:0] expWord(input logic [ADDR_W-1:0] a);
        int z;
        z = int'(a) - int'(OFF_TEMP12);
        case (a)
            OFF_BRIDGE: return {17'h0_0000, stk[3:0], 1'b0, stk[5:4]};
            OFF_ALERT: return {recoveryAlertIn, 5'h00, stk[13:6]};
            OFF_OPEN: return {stk[30:14], 5'h00, stk[31], stk[32]};
            OFF_THERM: return {watchdogPhase, 4'h0, ecvNotReachedIn, ecvAboveTargetIn,
                               2'h0, stk[38:33], 2'h0, stk[44:39]};
            OFF_TEMP12, OFF_TEMP34, OFF_TEMP56: begin
                return {2'h0, clusterTempCode[2*z+1], 2'h0, clusterTempCode[2*z]};
            end
            OFF_VREG: return {2'h0, regulatorSupplyCode, 12'h000};
            OFF_VSUP: return {2'h0, batterySupplyCode, 2'h0, wakePinVoltageCode};
            OFF_CAN: return {18'h0_0000, canSilentIn, 1'b0, stk[45], stk[46], 2'h0};
            default: return '0;
        endcase
    endfunction

    task automatic cmpBit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmpWord(input string nm, input logic [DATA_W-1:0] e,
                           input logic [DATA_W-1:0] g);
        compares++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one frame: note the answer, send it, then update the sticky model
    task automatic acc(input logic w, input logic c, input logic [ADDR_W-1:0] a);
        fms_note_t n;
        logic [N_FLAG-1:0] m;
        n.isErr = w || a < OFF_BRIDGE || a > OFF_CAN;
        n.word = expWord(a);
        q.push_back(n);
        host_u.frame(w, c, a);
        case (a)
            OFF_BRIDGE: m = 47'h0000_0000_003F;
            OFF_ALERT: m = 47'h0000_0000_3FC0;
            OFF_OPEN: m = 47'h0001_FFFF_C000;
            OFF_THERM: m = 47'h1FFE_0000_0000;
            OFF_CAN: m = 47'h6000_0000_0000;
            default: m = '0;
        endcase
        // held events win over the clear, refused frames clear nothing
        if (c && !n.isErr) stk = (stk & ~m) | evt;
    endtask

    // every mapped register back to back
    task automatic sweep(input logic c);
        for (int a = OFF_BRIDGE; a <= OFF_CAN; a++) acc(1'b0, c, 7'(a));
        host_u.idle();
    endtask

    // one-cycle event pulse, then wait past the synchroniser
    task automatic pulse(input logic [N_FLAG-1:0] v);
        @(posedge clock);
        #1 evt = v;
        stk |= v;
        @(posedge clock);
        #1 evt = '0;
        repeat (4) @(posedge clock);
    endtask

    // new random live levels and codes, settled before any read
    task automatic live();
        logic [31:0] r;
        @(posedge clock);
        #1 r = xs();
        recoveryAlertIn = r[10:0];
        {ecvNotReachedIn, ecvAboveTargetIn, canSilentIn} = r[13:11];
        watchdogPhase = r[15:14];
        r = xs();
        {regulatorSupplyCode, batterySupplyCode, wakePinVoltageCode} = r[29:0];
        for (int k = 0; k < 6; k++) clusterTempCode[k] = CODE_W'(xs());
        repeat (4) @(posedge clock);
    endtask

    task automatic giveVerdict();
        if (errCount == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // answer watcher: oldest note against each answer or refusal
    // looks mid-cycle, where the registered answer has long settled
    always @(negedge clock) begin
        if (rdValid === 1'b1 || invalidCmd === 1'b1) begin
            if (q.size() == 0) cmpBit("spare answer", 1'b0, 1'b1);
            else begin
                got = q.pop_front();
                cmpBit("invalidCmd", got.isErr, invalidCmd);
                cmpBit("rdValid", !got.isErr, rdValid);
                if (!got.isErr) cmpWord("rdData", got.word, rdData);
            end
        end
    end

    // hang guard, ten thousand cycles, far beyond what the run needs
    initial begin
        #200_000;
        errCount++;
        giveVerdict();
    end

    initial begin
        logic [63:0] v;
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        live();
        sweep(1'b0);
        for (int i = 0; i < 3; i++) begin
            live();
            v = {xs(), xs()};
            pulse(i == 0 ? {N_FLAG{1'b1}} : v[N_FLAG-1:0]);
            cmpBit("globalThermalWarning", |stk[38:33], globalThermalWarning);
            cmpBit("globalThermalShutdown", |stk[44:39], globalThermalShutdown);
            sweep(1'b0);
            sweep(1'b1);
            sweep(1'b0);
            cmpBit("globalThermalShutdown", 1'b0, globalThermalShutdown);
        end
        // refused frames: writes and unmapped offsets leave flags alone
        pulse({N_FLAG{1'b1}});
        acc(1'b1, 1'b1, OFF_ALERT);
        acc(1'b1, 1'b0, OFF_CAN);
        acc(1'b0, 1'b1, 7'h3D);
        acc(1'b0, 1'b1, 7'h32);
        acc(1'b0, 1'b0, OFF_ALERT);
        sweep(1'b1);
        // a second reset drops every latched flag
        pulse({N_FLAG{1'b1}});
        #1 rst = 1'b1;
        stk = '0;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        live();
        sweep(1'b0);
        // events held across the clear keep their flags
        @(posedge clock);
        #1 evt = {N_FLAG{1'b1}};
        stk = {N_FLAG{1'b1}};
        repeat (5) @(posedge clock);
        sweep(1'b1);
        sweep(1'b0);
        cmpBit("globalThermalShutdown", 1'b1, globalThermalShutdown);
        @(posedge clock);
        #1 evt = '0;
        repeat (5) @(posedge clock);
        sweep(1'b1);
        sweep(1'b0);
        // every watchdog phase code passes straight through
        for (int p = 0; p < 4; p++) begin
            @(posedge clock);
            #1 watchdogPhase = 2'(p);
            repeat (3) @(posedge clock);
            acc(1'b0, 1'b1, OFF_THERM);
            host_u.idle();
        end
        repeat (4) @(posedge clock);
        cmpBit("answers outstanding", 1'b1, q.size() == 0);
        giveVerdict();
    end
endmodule // fault_and_monitor_status_bank_test
